/* cfg_pins_defs.svh */
// Constants for the configuration pin controller.
`ifndef CFG_PINS_DEFS_SVH
`define CFG_PINS_DEFS_SVH
`define WORD_W        32
`define WSEL_X1       3'h0
`define WSEL_X2       3'h1
`define WSEL_X4       3'h2
`define WSEL_X8       3'h3
`define WSEL_X16      3'h4
`define WSEL_X32      3'h5
`define BITCNT_ZERO   6'h00
`define BITCNT_FULL   6'h20
`define SCLK_HALF     3'h4
`define CMD_BITS      5'h10
`define CMD_READ      8'h03
`define IR_LEN        4
`define IR_BYPASS     4'hF
`define IR_IDCODE     4'h1
`define IR_STATUS     4'h2
`define IR_PROGRAM    4'h3
`define IR_CAPTURE    4'h1
`endif

/* cfg_pins_pkg.sv */
// Types shared by the configuration pin controller.
`include "cfg_pins_defs.svh"
package cfg_pins_pkg;
    typedef enum logic [2:0] {
        CS_HOLD, CS_CMD, CS_LOAD, CS_RELEASE, CS_USER, CS_FAIL
    } cfg_state_e;
    typedef enum logic [3:0] {
        T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR,
        T_EX2_DR, T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR,
        T_PA_IR, T_EX2_IR, T_UPD_IR
    } tap_state_e;
    typedef struct packed {
        logic activeMode;
        logic loading;
        logic idErr;
        logic sumErr;
        logic userMode;
    } cfg_status_s;
endpackage

/* fpga_config_pin_control.sv */
// Configuration pin controller: serial loader, done/error pins and test port.
//
// Notes on behaviour
// (RL1) Done pin is open drain only.
// (RL2) No user mode while done pin held low.
// (RL3) Host pulses reconfigure request low, then high.
// (RL4) Reconfigure request restarts loading, no system reset.
// (RL5) Test port samples TMS, TDI on TCK rise.
// (RL6) Tester changes TMS, TDI after TCK fall.
// (RL7) Undriven TMS and TDI read as one.
// (RL8) TDI shifts through selected register to TDO.
// (RL9) TDO changes only after TCK fall.
// (RL10) TDO released when nothing is shifting.
// (RL11) Chip select low ignores configuration.
// (RL12) Data port up to 32 lines, width-selected.
// (RL13) Line 0: passive input, active output.
// (RL14) Line 1: passive output, active input.
// (RL15) Multi-bit chains share all 32 lines.
// (RL16) Serial clock input passive, driven output active.
// (RL17) Three-bit width select picks bus width.
// (RL18) Two-bit image select in multi-image mode.
// (RL19) Dedicated pins never become general I/O.
// (RL20) Dual-purpose pins freed in user mode.
// (RL21) Slave select sampled at reset release.
// (RL22) Error output low on id or sum failure.
// (RL23) Done pulled low until reload completes.
`timescale 1ns/1ps
`include "cfg_pins_defs.svh"
module fpga_config_pin_control #(
    parameter int          IMAGE_WORDS = 16,
    parameter logic [31:0] DEVICE_ID   = 32'h0A5C_0001  // Value is arbitrary.
) (
    input  wire logic        mclk,             // System clock.
    input  wire logic        rst,              // Synchronous reset.
    input  wire logic        cresetN,          // Reconfigure request pin.
    input  wire logic        slaveSelN,        // Mode strap pin.
    input  wire logic        chipSel,          // Configuration chip select.
    input  wire logic [2:0]  config_width_select, // Bus width select pins.
    input  wire logic [1:0]  image_select,     // Image select pins.
    input  wire logic        multiImageEn,     // External multi-image enable.
    input  wire logic        doneIn,           // Done pin level.
    output logic             doneOe,           // Done pin pull-low enable.
    output logic             error_status_n,   // Error status, low on fault.
    input  wire logic        sclkIn,           // Serial clock pin level.
    output logic             sclkOut,          // Serial clock drive value.
    output logic             sclkOe,           // Serial clock drive enable.
    input  wire logic [31:0] dataIn,           // Data line levels.
    output logic [31:0]      dataOut,          // Data line drive values.
    output logic [31:0]      dataOe,           // Data line drive enables.
    output logic             userMode,         // Device is in user mode.
    output cfg_pins_pkg::cfg_status_s status,  // Loader status.
    input  wire logic        tck,              // Test clock.
    input  wire logic        tmsIn,            // Test mode select pin.
    input  wire logic        tmsDriven,        // TMS pin is driven.
    input  wire logic        tdiIn,            // Test data in pin.
    input  wire logic        tdiDriven,        // TDI pin is driven.
    output logic             tdo,              // Test data out value.
    output logic             tdoOe             // Test data out enable.
);
    import cfg_pins_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers into the system clock domain.
    logic [41:0] pinS1_r;
    logic [41:0] pinS2_r;
    logic        sclkS3_r;
    always_ff @(posedge mclk) begin
        pinS1_r <= {cresetN, slaveSelN, chipSel, config_width_select,
                    image_select, doneIn, sclkIn, dataIn};
        pinS2_r <= pinS1_r;
        sclkS3_r <= pinS2_r[32];
    end
    logic        cresetS;
    logic        ssS;
    logic        csiS;
    logic [2:0]  widthS;
    logic [1:0]  imageS;
    logic        doneS;
    logic        sclkS;
    logic [31:0] dataS;
    assign {cresetS, ssS, csiS, widthS, imageS, doneS, sclkS, dataS} = pinS2_r;

    ////////////////////////////////////////////////////////////////////////
    // Loader state, straps and serial clock generation.
    cfg_state_e  state_r;
    logic        active_r;
    logic [2:0]  width_r;
    logic [15:0] cmd_r;
    logic [4:0]  cmdCnt_r;
    logic [2:0]  div_r;
    logic        sclk_r;
    logic        genRise;
    logic        genFall;
    logic        capture;
    logic        wordDone;
    logic        jtagWord;
    logic        lastWord;
    logic        idBad;
    logic        sumBad;
    logic [31:0] word;
    logic [31:0] wordCnt_r;

    assign genRise  = (div_r == `SCLK_HALF - 3'h1) && !sclk_r;
    assign genFall  = (div_r == `SCLK_HALF - 3'h1) && sclk_r;
    assign lastWord = (wordCnt_r == 32'(IMAGE_WORDS - 1));

    always_ff @(posedge mclk) begin
        if (rst || !cresetS) begin
            state_r <= CS_HOLD;                        // see (RL4)
        end else begin
            case (state_r)
                CS_HOLD:    state_r <= ssS ? CS_CMD : CS_LOAD; // see (RL21)
                CS_CMD:     if (genFall && cmdCnt_r == `CMD_BITS) begin
                    state_r <= CS_LOAD;
                end
                CS_LOAD:    if (wordDone) begin
                    if (idBad || sumBad) begin
                        state_r <= CS_FAIL;
                    end else if (lastWord) begin
                        state_r <= CS_RELEASE;
                    end
                end
                CS_RELEASE: if (doneS) begin
                    state_r <= CS_USER;                // see (RL2)
                end
                CS_USER:    state_r <= CS_USER;
                CS_FAIL:    state_r <= CS_FAIL;
                default:    state_r <= CS_HOLD;
            endcase
        end
    end

    // Straps are caught while the request pin is low, so they stand at release.
    always_ff @(posedge mclk) begin
        if (state_r == CS_HOLD) begin
            active_r <= ssS;                           // see (RL21)
            width_r  <= widthS;                        // see (RL17)
            cmd_r    <= {`CMD_READ, 6'h00,
                         multiImageEn ? imageS : 2'h0}; // see (RL18)
            cmdCnt_r <= 5'h00;
        end else if (state_r == CS_CMD) begin
            // The first fall only opens the frame; the top bit must still
            // stand at the first rise, so shifting waits for a rise.
            if (genFall && cmdCnt_r != 5'h00) begin
                cmd_r <= {cmd_r[14:0], 1'b0};
            end
            if (genRise) begin
                cmdCnt_r <= cmdCnt_r + 5'h01;
            end
        end
    end

    // Active mode: the device makes the serial clock by dividing mclk.
    always_ff @(posedge mclk) begin
        if (rst || !(active_r && (state_r == CS_CMD ||
                                  state_r == CS_LOAD))) begin
            div_r  <= 3'h0;
            sclk_r <= 1'b1;
        end else if (div_r == `SCLK_HALF - 3'h1) begin
            div_r  <= 3'h0;
            sclk_r <= !sclk_r;
        end else begin
            div_r  <= div_r + 3'h1;
        end
    end

    // Data is taken on a rising serial clock; the flash updates on the fall.
    assign capture = (state_r == CS_LOAD) && csiS &&   // see (RL11)
                     (active_r ? genRise : (sclkS && !sclkS3_r)); // see (RL16)

    ////////////////////////////////////////////////////////////////////////
    // Word assembly from the selected number of lines.
    logic [31:0] shift_r;
    logic [31:0] shiftNxt;
    logic [5:0]  bitCnt_r;
    logic [5:0]  step;
    logic [31:0] jtagData_r;
    logic [31:0] sum_r;
    logic        serialIn;

    assign serialIn = active_r ? dataS[1] : dataS[0];  // see (RL13) (RL14)

    always_comb begin
        shiftNxt = shift_r;
        step     = 6'h01;
        case (width_r)                                 // see (RL12) (RL17)
            `WSEL_X2:  begin shiftNxt = {shift_r[29:0], dataS[1:0]};
                       step = 6'h02; end
            `WSEL_X4:  begin shiftNxt = {shift_r[27:0], dataS[3:0]};
                       step = 6'h04; end
            `WSEL_X8:  begin shiftNxt = {shift_r[23:0], dataS[7:0]};
                       step = 6'h08; end
            `WSEL_X16: begin shiftNxt = {shift_r[15:0], dataS[15:0]};
                       step = 6'h10; end
            `WSEL_X32: begin shiftNxt = dataS;         // see (RL15)
                       step = 6'h20; end
            default:   shiftNxt = {shift_r[30:0], serialIn};
        endcase
    end

    assign wordDone = (capture && bitCnt_r + step == `BITCNT_FULL) ||
                      (state_r == CS_LOAD && jtagWord && csiS); // see (RL11)
    assign word     = jtagWord ? jtagData_r : shiftNxt;
    assign idBad    = (wordCnt_r == 32'h0) && (word != DEVICE_ID);
    assign sumBad   = lastWord && (word != sum_r);

    always_ff @(posedge mclk) begin
        if (state_r != CS_LOAD) begin
            bitCnt_r  <= `BITCNT_ZERO;
            wordCnt_r <= 32'h0;
            sum_r     <= 32'h0;
        end else begin
            if (capture) begin
                shift_r  <= shiftNxt;
                bitCnt_r <= (bitCnt_r + step == `BITCNT_FULL) ?
                            `BITCNT_ZERO : bitCnt_r + step;
            end
            if (wordDone) begin
                wordCnt_r <= wordCnt_r + 32'h1;
                if (wordCnt_r != 32'h0) begin
                    sum_r <= sum_r ^ word;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers.
    logic passiveLoad;
    assign passiveLoad = !active_r && state_r == CS_LOAD &&
                         (width_r == `WSEL_X1 || width_r > `WSEL_X32);

    always_ff @(posedge mclk) begin
        if (rst) begin
            doneOe         <= 1'b1;
            error_status_n <= 1'b1;
            userMode       <= 1'b0;
            sclkOut        <= 1'b1;
            sclkOe         <= 1'b0;
            dataOut        <= 32'h0000_0000;
            dataOe         <= 32'h0000_0000;
        end else begin
            // Only ever pulls low; the external pull-up makes the one.
            doneOe <= !(state_r == CS_RELEASE ||
                        state_r == CS_USER);           // see (RL1) (RL23)
            error_status_n <= !(state_r == CS_FAIL);   // see (RL22)
            userMode <= (state_r == CS_USER);
            sclkOut  <= sclk_r;
            sclkOe   <= active_r && (state_r == CS_CMD ||
                                     state_r == CS_LOAD); // see (RL16)
            dataOut  <= 32'h0000_0000;
            dataOe   <= 32'h0000_0000;
            if (state_r == CS_CMD) begin
                dataOut[0] <= cmd_r[15];               // see (RL13)
                dataOe[0]  <= 1'b1;
            end else if (passiveLoad) begin
                dataOut[1] <= shift_r[31];             // see (RL14)
                dataOe[1]  <= 1'b1;
            end
            // In user mode every dual-purpose line is left undriven here.
            if (state_r == CS_USER) begin
                dataOe <= 32'h0000_0000;               // see (RL20)
                sclkOe <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            status <= '0;
        end else begin
            status.activeMode <= active_r;
            status.loading    <= (state_r == CS_LOAD);
            status.idErr      <= (state_r == CS_LOAD) && wordDone && idBad ?
                                 1'b1 : (state_r == CS_HOLD ? 1'b0 :
                                 status.idErr);
            status.sumErr     <= (state_r == CS_LOAD) && wordDone && sumBad ?
                                 1'b1 : (state_r == CS_HOLD ? 1'b0 :
                                 status.sumErr);
            status.userMode   <= (state_r == CS_USER);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test access port on the test clock. The dedicated test pins are never
    // handed to user logic.                         see (RL19)
    tap_state_e      tap_r;
    tap_state_e      tapNxt;
    logic [3:0]      ir_r;
    logic [3:0]      irShift_r;
    logic [31:0]     dr_r;
    logic            bypass_r;
    logic            tms;
    logic            tdi;
    logic [1:0]      rstT_r;
    cfg_status_s     stT1_r;
    cfg_status_s     stT2_r;
    logic            progTgl_r;

    assign tms = tmsIn | !tmsDriven;                   // see (RL7)
    assign tdi = tdiIn | !tdiDriven;                   // see (RL7)

    always_comb begin
        case (tap_r)
            T_RESET:  tapNxt = tms ? T_RESET  : T_IDLE;
            T_IDLE:   tapNxt = tms ? T_SEL_DR : T_IDLE;
            T_SEL_DR: tapNxt = tms ? T_SEL_IR : T_CAP_DR;
            T_CAP_DR: tapNxt = tms ? T_EX1_DR : T_SH_DR;
            T_SH_DR:  tapNxt = tms ? T_EX1_DR : T_SH_DR;
            T_EX1_DR: tapNxt = tms ? T_UPD_DR : T_PA_DR;
            T_PA_DR:  tapNxt = tms ? T_EX2_DR : T_PA_DR;
            T_EX2_DR: tapNxt = tms ? T_UPD_DR : T_SH_DR;
            T_UPD_DR: tapNxt = tms ? T_SEL_DR : T_IDLE;
            T_SEL_IR: tapNxt = tms ? T_RESET  : T_CAP_IR;
            T_CAP_IR: tapNxt = tms ? T_EX1_IR : T_SH_IR;
            T_SH_IR:  tapNxt = tms ? T_EX1_IR : T_SH_IR;
            T_EX1_IR: tapNxt = tms ? T_UPD_IR : T_PA_IR;
            T_PA_IR:  tapNxt = tms ? T_EX2_IR : T_PA_IR;
            T_EX2_IR: tapNxt = tms ? T_UPD_IR : T_SH_IR;
            T_UPD_IR: tapNxt = tms ? T_SEL_DR : T_IDLE;
            default:  tapNxt = T_RESET;
        endcase
    end

    always_ff @(posedge tck) begin
        rstT_r <= {rstT_r[0], rst};
        stT1_r <= status;
        stT2_r <= stT1_r;
    end

    always_ff @(posedge tck) begin                     // see (RL5)
        if (rstT_r[1]) begin
            tap_r     <= T_RESET;
            ir_r      <= `IR_IDCODE;
            irShift_r <= `IR_CAPTURE;
            progTgl_r <= 1'b0;
        end else begin
            tap_r <= tapNxt;
            if (tap_r == T_RESET) begin
                ir_r <= `IR_IDCODE;
            end
            case (tap_r)                               // see (RL8)
                T_CAP_IR: irShift_r <= `IR_CAPTURE;
                T_SH_IR:  irShift_r <= {tdi, irShift_r[3:1]};
                T_UPD_IR: ir_r      <= irShift_r;
                T_CAP_DR: begin
                    bypass_r <= 1'b0;
                    case (ir_r)
                        `IR_IDCODE: dr_r <= DEVICE_ID;
                        `IR_STATUS: dr_r <= 32'(stT2_r);
                        default:    dr_r <= 32'h0000_0000;
                    endcase
                end
                T_SH_DR: begin
                    bypass_r <= tdi;
                    dr_r     <= {tdi, dr_r[31:1]};
                end
                T_UPD_DR: if (ir_r == `IR_PROGRAM) begin
                    progTgl_r <= !progTgl_r;
                end
                default: ;
            endcase
        end
    end

    always_ff @(negedge tck) begin                     // see (RL9)
        if (rstT_r[1]) begin
            tdo   <= 1'b1;
            tdoOe <= 1'b0;
        end else begin
            tdoOe <= (tap_r == T_SH_IR || tap_r == T_SH_DR); // see (RL10)
            if (tap_r == T_SH_IR) begin
                tdo <= irShift_r[0];
            end else if (ir_r == `IR_BYPASS) begin
                tdo <= bypass_r;
            end else begin
                tdo <= dr_r[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program words cross by toggle; the word is still until the next capture.
    logic [2:0] progS_r;
    always_ff @(posedge mclk) begin
        progS_r    <= {progS_r[1:0], progTgl_r};
        jtagData_r <= dr_r;
    end
    assign jtagWord = progS_r[2] ^ progS_r[1];

endmodule

/* fpga_config_pin_control_props.sv */
// Concurrent checks on the configuration pin controller ports.
`timescale 1ns/1ps
module fpga_config_pin_control_props (
    input wire logic                      mclk,           // System clock.
    input wire logic                      rst,            // Sync reset.
    input wire logic                      cresetN,        // Reload request.
    input wire logic                      doneIn,         // Done pin level.
    input wire logic                      doneOe,         // Done pull-low.
    input wire logic                      error_status_n, // Error status.
    input wire logic                      sclkOut,        // Serial clock.
    input wire logic                      sclkOe,         // Clock enable.
    input wire logic [31:0]               dataOe,         // Line enables.
    input wire logic                      userMode,       // User mode.
    input wire cfg_pins_pkg::cfg_status_s status          // Loader status.
);
    import cfg_pins_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence reqHeld;
        !cresetN [*6];
    endsequence
    sequence clkHighPhase;
        sclkOut [*4] ##1 !sclkOut;
    endsequence
    chk_user_needs_done: assert property (
        $rose(userMode) |-> $past(doneIn, 3))
        else $error("user mode entered while done pin was low");
    chk_user_after_release: assert property (
        $rose(userMode) |-> $past(doneOe, 3) == 1'b0)
        else $error("user mode came too soon after done release");
    chk_reload_pulls_done: assert property (
        reqHeld |-> doneOe && !userMode)
        else $error("done not pulled low during reload request");
    chk_user_pins_free: assert property (
        userMode |-> !doneOe && error_status_n && !sclkOe &&
            dataOe == 32'h0000_0000)
        else $error("pins still driven in user mode");
    chk_error_latches: assert property (
        !error_status_n && cresetN |=> !error_status_n && doneOe)
        else $error("error status dropped without reload");
    chk_passive_lines: assert property (
        status.loading && !status.activeMode |-> !sclkOe && !dataOe[0])
        else $error("passive load drives clock or line zero");
    chk_active_lines: assert property (
        status.loading && status.activeMode |-> sclkOe && !dataOe[1])
        else $error("active load misdrives clock or line one");
    chk_clk_period: assert property (
        @(posedge mclk) disable iff (rst || !cresetN)
        $rose(sclkOut) && sclkOe |-> clkHighPhase)
        else $error("serial clock high phase not four cycles");
endmodule
bind fpga_config_pin_control fpga_config_pin_control_props i_props (
    .mclk(mclk), .rst(rst), .cresetN(cresetN), .doneIn(doneIn),
    .doneOe(doneOe), .error_status_n(error_status_n), .sclkOut(sclkOut),
    .sclkOe(sclkOe), .dataOe(dataOe), .userMode(userMode), .status(status)
);

/* cfg_host_model.sv */
// Passive configuration host that clocks image words into the device.
`timescale 1ns/1ps
module cfg_host_model (
    output logic        sclkPin,  // Serial clock drive, idle high.
    output logic [31:0] linesPin  // Data line drive.
);
    // Half period of four system clocks stays above the sync limit.
    localparam int HALF = 160;
    initial begin
        sclkPin = 1'b1;
        linesPin = 32'h0000_0000;
    end
    task automatic sendWord(input logic [31:0] word, input int w);
        int c;
        int l;
        for (c = 0; c < 32 / w; c++) begin
            sclkPin = 1'b0;
            for (l = 0; l < w; l++) begin
                linesPin[l] = word[31 - c * w - (w - 1 - l)];
            end
            #HALF;
            sclkPin = 1'b1;
            #HALF;
        end
        // Released lines show a changed value rather than the last bit.
        linesPin = ~linesPin;
    endtask
endmodule

/* tb.sv */
// Self-checking bench for the configuration pin controller.
`timescale 1ns/1ps
`include "cfg_pins_defs.svh"
module tb;
    import cfg_pins_pkg::*;
    localparam int          WORDS = 3;
    localparam logic [31:0] ID = 32'h1234_5678; // Value is arbitrary.
    logic mclk = 1'b0, tck = 1'b0, rst = 1'b1, tckRun = 1'b1;
    logic cresetN = 1'b1, slaveSelN = 1'b0, chipSel = 1'b1;
    logic [2:0] widthSel = 3'h0;
    logic [1:0] imageSel = 2'h0;
    logic multiImageEn = 1'b0, holdDone = 1'b0;
    logic tmsIn = 1'b0, tmsDriven = 1'b0, tdiIn = 1'b0, tdiDriven = 1'b1;
    logic doneOe, errN, sclkOut, sclkOe, userMode, tdo, tdoOe, hostSclk;
    logic bitSeen;
    logic [31:0] dataOut, dataOe, hostLines, seen;
    logic [15:0] hdr;
    cfg_status_s status;
    int c, errTotal = 0, compares = 0;
    // Open-drain done pin with its external pull-up.
    wire doneIn = !(doneOe || holdDone);
    wire sclkIn = sclkOe ? sclkOut : hostSclk;
    wire [31:0] dataIn = (dataOe & dataOut) | (~dataOe & hostLines);
    fpga_config_pin_control #(.IMAGE_WORDS(WORDS), .DEVICE_ID(ID)) i_dut (
        .mclk(mclk), .rst(rst), .cresetN(cresetN), .slaveSelN(slaveSelN),
        .chipSel(chipSel), .config_width_select(widthSel),
        .image_select(imageSel), .multiImageEn(multiImageEn),
        .doneIn(doneIn), .doneOe(doneOe), .error_status_n(errN),
        .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOe(sclkOe),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .userMode(userMode), .status(status), .tck(tck), .tmsIn(tmsIn),
        .tmsDriven(tmsDriven), .tdiIn(tdiIn), .tdiDriven(tdiDriven),
        .tdo(tdo), .tdoOe(tdoOe));
    cfg_host_model i_host (.sclkPin(hostSclk), .linesPin(hostLines));
    always #20 mclk = ~mclk;
    // The test clock stops low once tckRun is cleared after the last scan.
    always begin
        #3;
        if (tckRun || tck) tck = ~tck;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: saw %h want %h", $time, got, exp);
        end
    endtask
    task automatic printVerdict;
        if (errTotal == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #1_000_000;
        errTotal++;
        printVerdict;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tapBit(input logic tms, input logic tdi, output logic o);
        @(negedge tck);
        tmsIn = tms;
        tdiIn = tdi;
        @(posedge tck);
        o = tdo;
        #2;
        check(tdo, o);
    endtask
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        int i;
        dout = 32'h0000_0000;
        tapBit(1'b1, 1'b0, o);
        if (ir) tapBit(1'b1, 1'b0, o);
        tapBit(1'b0, 1'b0, o);
        tapBit(1'b0, 1'b0, o);
        for (i = 0; i < n; i++) begin
            tapBit(i == n - 1, din[i], o);
            dout[i] = o;
            check(tdoOe, 1'b1);
        end
        tapBit(1'b1, 1'b0, o);
        tapBit(1'b0, 1'b0, o);
        check(tdoOe, 1'b0);
    endtask
    task automatic reload(input logic act, input logic [2:0] w);
        @(negedge mclk);
        cresetN = 1'b0;
        slaveSelN = act;
        widthSel = w;
        repeat (8) @(negedge mclk);
        check({doneOe, userMode, errN}, 3'b101);
        cresetN = 1'b1;
        @(negedge mclk);
    endtask
    task automatic sendImage(input logic [31:0] idFix,
                             input logic [31:0] sumFix, input int w);
        logic [31:0] word;
        logic [31:0] sum;
        int k;
        sum = 32'h0000_0000;
        i_host.sendWord(ID ^ idFix, w);
        if (chipSel)
            check(dataOe[1:0], {w == 1 && !idFix, 1'b0});
        for (k = 1; k < WORDS - 1; k++) begin
            word = 32'h9E37_79B9 * k;
            sum = sum ^ word;
            i_host.sendWord(word, w);
        end
        i_host.sendWord(sum ^ sumFix, w);
        repeat (6) @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge mclk);
        check({doneOe, tdoOe}, 2'b10);
        rst = 1'b0;
        tmsDriven = 1'b1;
        repeat (3) tapBit(1'b0, 1'b0, bitSeen);
        scan(1'b1, 4, `IR_BYPASS, seen);
        check(seen[3:0], `IR_CAPTURE);
        scan(1'b0, 8, 32'h0000_00A5, seen);
        check(seen[7:0], 8'h4A);
        tdiDriven = 1'b0;
        scan(1'b0, 8, 32'h0000_0000, seen);
        check(seen[7:0], 8'hFE);
        tdiDriven = 1'b1;
        tmsDriven = 1'b0;
        repeat (5) tapBit(1'b0, 1'b0, bitSeen);
        tmsDriven = 1'b1;
        tapBit(1'b0, 1'b0, bitSeen);
        scan(1'b0, 32, 32'h0000_0000, seen);
        check(seen, ID);
        scan(1'b1, 4, `IR_STATUS, seen);
        scan(1'b0, 32, 32'h0000_0000, seen);
        check(seen, 32'h0000_0008);
        tckRun = 1'b0;
        for (c = 0; c < 7; c++) begin
            reload(1'b0, c[2:0]);
            holdDone = 1'b1;
            sendImage(32'h0000_0000, 32'h0000_0000, c < 6 ? 1 << c : 1);
            check({doneOe, userMode}, 2'b00);
            holdDone = 1'b0;
            repeat (6) @(negedge mclk);
            check({userMode, errN}, 2'b11);
            check(dataOe, 32'h0000_0000);
        end
        for (c = 0; c < 3; c++) begin
            reload(1'b0, `WSEL_X1);
            chipSel = c != 2;
            sendImage(c == 0 ? 32'h0000_0001 : 32'h0000_0000,
                      c == 1 ? 32'h0000_0100 : 32'h0000_0000, 1);
            check({errN, doneOe, userMode}, {c == 2, 2'b10});
            check(status, {1'b0, c == 2, c == 0, c == 1, 1'b0});
        end
        chipSel = 1'b1;
        multiImageEn = 1'b1;
        imageSel = 2'h2;
        reload(1'b1, `WSEL_X1);
        for (c = 0; c < 16; c++) begin
            @(posedge sclkOut);
            hdr = {hdr[14:0], dataOut[0]};
        end
        check({sclkOe, dataOe[1]}, 2'b10);
        check(hdr, {`CMD_READ, 6'h00, imageSel});
        reload(1'b0, `WSEL_X1);
        printVerdict;
    end
endmodule
